// ### src/lfw_mode_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Listen runs enabled channels; carrier starts RSSI
// - Standard listening keeps enabled channels all on
// - Scanning rotates one channel per 1 ms
// - Carrier during scan activates all three channels
// - Strongest RSSI channel goes to demodulator
// - On/off: 1 ms on, field-selected off
// - Quiet window pulses wake for 128 us
// - Eight-bit false-wakeup count readable by host
// - Correlator enabled: preamble then pattern search
// - Correlator disabled: straight into data receiving
// - Pattern match raises wake, enters data receiving
// - Pattern fail ends wakeup without interrupt
// - Data shown during correlation only when pre_wake_data_hide is set
// - Data receiving outputs data and recovered clock
// - Clear-wake command returns to listening
// - Timeout returns data receiving to listening
// - Registers reached by host over serial port
// - RC trim from serial port or auto
// - Clock generator source: crystal, RC, external
// - Off-time code 00 is 1 ms, 01 2 ms
module lfw_mode_ctrl #(
  parameter int SLOT_CYC = lfw_pkg::SLOT_CYC,
  parameter int WAKE_PULSE_CYC = lfw_pkg::WAKE_PULSE_CYC,
  parameter int AW_UNIT_MS = lfw_pkg::AW_UNIT_MS,
  parameter int TO_UNIT_MS = lfw_pkg::TO_UNIT_MS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic fe_clk,
  input wire lfw_pkg::lfw_cfg_t cfg,
  input wire logic clear_wake,
  input wire logic [4:0] rc_auto_trim,
  input wire logic [2:0] carrier_det,
  input wire logic demod_in,
  input wire logic rec_clk_in,
  input wire logic patt_match,
  input wire logic patt_fail,
  input wire lfw_pkg::lfw_rssi_t rssi_in,
  output logic [2:0] chan_active,
  output logic [1:0] demod_sel,
  output lfw_pkg::lfw_rssi_t rssi_stored,
  output logic [7:0] false_wake_cnt,
  output logic wake_out,
  output logic demod_data_out,
  output logic recovered_clock_out,
  output lfw_pkg::lfw_osc_en_t osc_en,
  output logic [4:0] rc_trim_out,
  output logic [1:0] mode_state
);
  lfw_pkg::lfw_state_t state_q, state_d;
  logic [31:0] tick_cnt_q;
  logic ms_tick;
  logic [2:0] scan_ch_q;
  logic onoff_on_q;
  logic [3:0] off_ms_q;
  logic [3:0] off_len;
  logic [31:0] aw_ms_q;
  logic [31:0] aw_win;
  logic [31:0] aw_pulse_q;
  logic aw_fire;
  logic [31:0] to_ms_q;
  logic to_fire;
  logic [2:0] car_s1_q, car_s2_q;
  logic carrier_any;
  logic [1:0] dat_s1_q, dat_s2_q;
  logic req_q, ack_s1_q, ack_s2_q, rssi_done;
  logic [2:0] match_s_q, fail_s_q;
  logic match_ev, fail_ev;
  logic req_s1_q, req_s2_q, ack_q;
  logic match_tgl_q, fail_tgl_q;
  lfw_pkg::lfw_rssi_t rssi_hold_q;
  logic [7:0] fw_cnt_q;
  logic wake_q, data_q, rclk_q;
  logic [2:0] chan_q;
  logic [1:0] sel_q;
  lfw_pkg::lfw_rssi_t rssi_q;

  // Next enabled channel after the current one, wrapping 3 -> 1
  function automatic logic [2:0] next_ch(input logic [2:0] cur,
                                         input logic [2:0] en);
    logic [2:0] c;
    c = cur;
    for (int i = 0; i < lfw_pkg::NCH; i++) begin
      c = {c[1:0], c[2]};
      if ((c & en) != 3'h0) begin
        return c;
      end
    end
    return lfw_pkg::CH1_ONLY;
  endfunction : next_ch

  // Front-end domain: pattern events become toggles, RSSI words are held
  // stable before the acknowledge toggle is returned
  always_ff @(posedge fe_clk or negedge resetn) begin
    if (!resetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q <= 1'b0;
      match_tgl_q <= 1'b0;
      fail_tgl_q <= 1'b0;
      rssi_hold_q <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      match_tgl_q <= match_tgl_q ^ patt_match;
      fail_tgl_q <= fail_tgl_q ^ patt_fail;
      if (req_s2_q != ack_q) begin
        rssi_hold_q <= rssi_in;
        ack_q <= req_s2_q;
      end
    end
  end

  // Synchronisers into mclk; pins and fe_clk toggles pass two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      car_s1_q <= 3'h0;
      car_s2_q <= 3'h0;
      dat_s1_q <= 2'h0;
      dat_s2_q <= 2'h0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      match_s_q <= 3'h0;
      fail_s_q <= 3'h0;
    end else begin
      car_s1_q <= carrier_det;
      car_s2_q <= car_s1_q;
      dat_s1_q <= {rec_clk_in, demod_in};
      dat_s2_q <= dat_s1_q;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      match_s_q <= {match_s_q[1:0], match_tgl_q};
      fail_s_q <= {fail_s_q[1:0], fail_tgl_q};
    end
  end

  assign match_ev = match_s_q[2] ^ match_s_q[1];
  assign fail_ev = fail_s_q[2] ^ fail_s_q[1];
  // Only channels that are powered may report a carrier
  assign carrier_any = |(car_s2_q & chan_q);
  assign rssi_done = (state_q == lfw_pkg::ST_EVAL) && (ack_s2_q == req_q);

  // Millisecond tick, restarted during evaluation so later slots are whole
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0;
    end else if (ms_tick || (state_q == lfw_pkg::ST_EVAL)) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign ms_tick = (tick_cnt_q == 32'(SLOT_CYC - 1));

  // Off-time decode
  always_comb begin
    case (cfg.off_time_sel)
      lfw_pkg::OFF_CODE_C0: off_len = lfw_pkg::OFF_MS_C0;
      lfw_pkg::OFF_CODE_C1: off_len = lfw_pkg::OFF_MS_C1;
      lfw_pkg::OFF_CODE_C2: off_len = lfw_pkg::OFF_MS_C2;
      default: off_len = lfw_pkg::OFF_MS_C3;
    endcase
  end

  // Scan rotation and on/off duty cycle, both stepped on the ms tick
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scan_ch_q <= lfw_pkg::CH1_ONLY;
      onoff_on_q <= 1'b1;
      off_ms_q <= 4'h0;
    end else if (state_q != lfw_pkg::ST_LISTEN) begin
      scan_ch_q <= lfw_pkg::CH1_ONLY;
      onoff_on_q <= 1'b1;
      off_ms_q <= 4'h0;
    end else if (ms_tick) begin
      scan_ch_q <= next_ch(scan_ch_q, cfg.chan_en);
      if (onoff_on_q) begin
        onoff_on_q <= 1'b0;
        off_ms_q <= 4'h0;
      end else if (off_ms_q + 4'h1 == off_len) begin
        onoff_on_q <= 1'b1;
      end else begin
        off_ms_q <= off_ms_q + 4'h1;
      end
    end
  end

  // Channel power: all three once a carrier is being evaluated
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chan_q <= 3'h0;
    end else if (state_d != lfw_pkg::ST_LISTEN) begin
      chan_q <= lfw_pkg::ALL_CH;
    end else if (cfg.scan_rotation_en) begin
      chan_q <= scan_ch_q & cfg.chan_en;
    end else if (cfg.on_off_en) begin
      chan_q <= onoff_on_q ? cfg.chan_en : 3'h0;
    end else begin
      chan_q <= cfg.chan_en;
    end
  end

  // Artificial wakeup: quiet window, then a fixed wake pulse
  assign aw_win = 32'(AW_UNIT_MS) << cfg.art_wake_sel;
  assign aw_fire = cfg.art_wake_en && (state_q == lfw_pkg::ST_LISTEN) &&
                   ms_tick && (aw_ms_q + 32'h1 >= aw_win);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_ms_q <= 32'h0;
      aw_pulse_q <= 32'h0;
    end else begin
      if (aw_fire || carrier_any || !cfg.art_wake_en ||
          state_q != lfw_pkg::ST_LISTEN) begin
        aw_ms_q <= 32'h0;
      end else if (ms_tick) begin
        aw_ms_q <= aw_ms_q + 32'h1;
      end
      if (aw_fire) begin
        aw_pulse_q <= 32'(WAKE_PULSE_CYC);
      end else if (aw_pulse_q != 32'h0) begin
        aw_pulse_q <= aw_pulse_q - 32'h1;
      end
    end
  end

  // Data receiving timeout in ms
  assign to_fire = cfg.timeout_en && (state_q == lfw_pkg::ST_DATA) &&
    ms_tick && (to_ms_q + 32'h1 >= 32'(TO_UNIT_MS) *
    (32'(cfg.timeout_sel) + 32'h1));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      to_ms_q <= 32'h0;
    end else if (state_q != lfw_pkg::ST_DATA || to_fire) begin
      to_ms_q <= 32'h0;
    end else if (ms_tick) begin
      to_ms_q <= to_ms_q + 32'h1;
    end
  end

  // Mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      lfw_pkg::ST_LISTEN: begin
        if (carrier_any) begin
          state_d = lfw_pkg::ST_EVAL;
        end
      end
      lfw_pkg::ST_EVAL: begin
        if (rssi_done) begin
          state_d = cfg.correlator_en ? lfw_pkg::ST_CORR
                                      : lfw_pkg::ST_DATA;
        end
      end
      lfw_pkg::ST_CORR: begin
        if (match_ev) begin
          state_d = lfw_pkg::ST_DATA;
        end else if (fail_ev) begin
          state_d = lfw_pkg::ST_LISTEN;
        end
      end
      lfw_pkg::ST_DATA: begin
        if (clear_wake || to_fire) begin
          state_d = lfw_pkg::ST_LISTEN;
        end
      end
      default: state_d = lfw_pkg::ST_LISTEN;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= lfw_pkg::ST_LISTEN;
    end else begin
      state_q <= state_d;
    end
  end

  // RSSI request toggles on entry to evaluation; result and winner kept
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_q <= 1'b0;
      rssi_q <= '0;
      sel_q <= 2'h0;
    end else begin
      if (state_q == lfw_pkg::ST_LISTEN && carrier_any) begin
        req_q <= ~req_q;
      end
      if (rssi_done) begin
        rssi_q <= rssi_hold_q;
        if (rssi_hold_q.ch1 >= rssi_hold_q.ch2 &&
            rssi_hold_q.ch1 >= rssi_hold_q.ch3) begin
          sel_q <= 2'h0;
        end else if (rssi_hold_q.ch2 >= rssi_hold_q.ch3) begin
          sel_q <= 2'h1;
        end else begin
          sel_q <= 2'h2;
        end
      end
    end
  end

  // False-wakeup count saturates rather than wrapping to a calm reading
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fw_cnt_q <= lfw_pkg::FWAKE_RST;
    end else if (state_q == lfw_pkg::ST_CORR && !match_ev && fail_ev &&
                 fw_cnt_q != lfw_pkg::FWAKE_MAX) begin
      fw_cnt_q <= fw_cnt_q + 8'h1;
    end
  end

  // Wake, data and recovered clock pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
      data_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wake_q <= (state_d == lfw_pkg::ST_DATA) || aw_fire ||
                (aw_pulse_q > 32'h1);
      // The bit set shows data during correlation, despite its name
      data_q <= ((state_q == lfw_pkg::ST_CORR && cfg.pre_wake_data_hide) ||
                 state_q == lfw_pkg::ST_DATA) && dat_s2_q[0];
      rclk_q <= state_q == lfw_pkg::ST_DATA && cfg.manchester_decoder_en &&
                dat_s2_q[1];
    end
  end

  // Configuration arrives from the serial-port register file
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_en <= '0;
      rc_trim_out <= 5'h00;
    end else begin
      osc_en.xtal <= cfg.clk_src == lfw_pkg::CS_XTAL;
      osc_en.rc <= cfg.clk_src == lfw_pkg::CS_RC;
      osc_en.ext <= cfg.clk_src == lfw_pkg::CS_EXT;
      rc_trim_out <= cfg.rc_cal_auto ? rc_auto_trim : cfg.rc_trim;
    end
  end

  assign chan_active = chan_q;
  assign demod_sel = sel_q;
  assign rssi_stored = rssi_q;
  assign false_wake_cnt = fw_cnt_q;
  assign wake_out = wake_q;
  assign demod_data_out = data_q;
  assign recovered_clock_out = rclk_q;
  assign mode_state = state_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_corr_match;
    state_q == lfw_pkg::ST_CORR && match_ev;
  endsequence
  sequence s_wake_data;
    wake_out && state_q == lfw_pkg::ST_DATA;
  endsequence

  chk_std_listen: assert property (
    state_q == lfw_pkg::ST_LISTEN && state_d == lfw_pkg::ST_LISTEN &&
    !cfg.scan_rotation_en && !cfg.on_off_en
    |=> chan_active == $past(cfg.chan_en))
    else $error("standard listening channel mismatch");
  chk_scan_single: assert property (
    state_q == lfw_pkg::ST_LISTEN && state_d == lfw_pkg::ST_LISTEN &&
    cfg.scan_rotation_en |=> $onehot0(chan_active))
    else $error("more than one channel in scan");
  chk_eval_all: assert property (
    state_q != lfw_pkg::ST_LISTEN |-> chan_active == lfw_pkg::ALL_CH)
    else $error("not all channels active after carrier");
  chk_corr_entry: assert property (
    rssi_done && cfg.correlator_en |=> state_q == lfw_pkg::ST_CORR)
    else $error("correlation not entered");
  chk_corr_bypass: assert property (
    rssi_done && !cfg.correlator_en |=> state_q == lfw_pkg::ST_DATA)
    else $error("correlator bypass failed");
  chk_match_wake: assert property (
    s_corr_match |=> s_wake_data)
    else $error("match did not raise wake");
  chk_fail_quiet: assert property (
    state_q == lfw_pkg::ST_CORR && fail_ev && !match_ev
    |=> state_q == lfw_pkg::ST_LISTEN && !wake_out)
    else $error("failed pattern raised wake");
  chk_data_hidden: assert property (
    state_q == lfw_pkg::ST_CORR && !cfg.pre_wake_data_hide |=> !demod_data_out)
    else $error("data shown before wake");
  chk_clear_wake: assert property (
    state_q == lfw_pkg::ST_DATA && clear_wake
    |=> state_q == lfw_pkg::ST_LISTEN && !wake_out)
    else $error("clear-wake not obeyed");
  chk_aw_pulse: assert property (
    aw_fire |=> wake_out [*8])
    else $error("artificial wake pulse too short");
  chk_fwake_count: assert property (
    state_q == lfw_pkg::ST_CORR && fail_ev && !match_ev &&
    fw_cnt_q != lfw_pkg::FWAKE_MAX |=> fw_cnt_q == $past(fw_cnt_q) + 8'h1)
    else $error("false wakeup count not incremented");
endmodule : lfw_mode_ctrl

// ### src/lfw_pkg.sv
package lfw_pkg;
  // Clock and time base
  localparam int MCLK_PERIOD_PS = 25000;
  localparam int PS_PER_US = 1000000;
  localparam int SLOT_US = 1000;
  localparam int SLOT_CYC = (SLOT_US * PS_PER_US) / MCLK_PERIOD_PS;
  localparam int WAKE_PULSE_US = 128;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_US * PS_PER_US) /
                                  MCLK_PERIOD_PS;
  // On/off off-time in ms per field code
  localparam logic [3:0] OFF_MS_C0 = 4'h1;
  localparam logic [3:0] OFF_MS_C1 = 4'h2;
  localparam logic [3:0] OFF_MS_C2 = 4'h4;
  localparam logic [3:0] OFF_MS_C3 = 4'h8;
  localparam logic [1:0] OFF_CODE_C0 = 2'h0;
  localparam logic [1:0] OFF_CODE_C1 = 2'h1;
  localparam logic [1:0] OFF_CODE_C2 = 2'h2;
  // Unit of the artificial wakeup window and of the data timeout, in ms
  localparam int AW_UNIT_MS = 1000;
  localparam int TO_UNIT_MS = 100;
  // Counter widths and reset values
  localparam int NCH = 3;
  localparam int RSSI_W = 5;
  localparam int FWAKE_W = 8;
  localparam logic [7:0] FWAKE_RST = 8'h00;
  localparam logic [7:0] FWAKE_MAX = 8'hFF;
  localparam logic [2:0] CH1_ONLY = 3'h1;
  localparam logic [2:0] ALL_CH = 3'h7;

  typedef enum logic [1:0] {CS_XTAL, CS_RC, CS_EXT} lfw_clksrc_t;

  typedef enum logic [1:0] {ST_LISTEN, ST_EVAL, ST_CORR, ST_DATA}
    lfw_state_t;

  typedef struct packed {
    logic [2:0] chan_en;
    logic scan_rotation_en;
    logic on_off_en;
    logic [1:0] off_time_sel;
    logic art_wake_en;
    logic [2:0] art_wake_sel;
    logic correlator_en;
    logic pre_wake_data_hide;
    logic manchester_decoder_en;
    logic timeout_en;
    logic [2:0] timeout_sel;
    lfw_clksrc_t clk_src;
    logic rc_cal_auto;
    logic [4:0] rc_trim;
  } lfw_cfg_t;

  typedef struct packed {
    logic [4:0] ch3;
    logic [4:0] ch2;
    logic [4:0] ch1;
  } lfw_rssi_t;

  typedef struct packed {
    logic xtal;
    logic rc;
    logic ext;
  } lfw_osc_en_t;
endpackage : lfw_pkg

// ### testbench/lfw_fe_model.sv
`timescale 1ns/1ps
// Stand-in for the front end and correlator on the link clock
module lfw_fe_model (
  input wire logic fe_clk,
  input wire logic resetn,
  input wire logic match_tgl,
  input wire logic fail_tgl,
  input wire lfw_pkg::lfw_rssi_t rssi_val,
  output logic patt_match,
  output logic patt_fail,
  output lfw_pkg::lfw_rssi_t rssi_in
);
  logic m_q;
  logic f_q;

  // A bench toggle becomes one link-clock pulse, so no pulse can be missed
  always_ff @(posedge fe_clk or negedge resetn) begin
    if (!resetn) begin
      m_q <= 1'b0;
      f_q <= 1'b0;
      patt_match <= 1'b0;
      patt_fail <= 1'b0;
    end else begin
      m_q <= match_tgl;
      f_q <= fail_tgl;
      patt_match <= m_q ^ match_tgl;
      patt_fail <= f_q ^ fail_tgl;
    end
  end

  // Per-channel strength words change only on the link clock
  always_ff @(posedge fe_clk or negedge resetn) begin
    if (!resetn) begin
      rssi_in <= '0;
    end else begin
      rssi_in <= rssi_val;
    end
  end
endmodule : lfw_fe_model

// ### testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  localparam int SLOT = 20;
  logic mclk, fe_clk, resetn, clear_wake, demod_in, rec_clk_in;
  logic m_tgl, f_tgl, patt_match, patt_fail;
  logic [2:0] carrier_det;
  logic [4:0] rc_auto_trim;
  lfw_pkg::lfw_cfg_t cfg;
  lfw_pkg::lfw_rssi_t rssi_val, rssi_in, rssi_stored;
  lfw_pkg::lfw_osc_en_t osc_en;
  logic [2:0] chan_active;
  logic [1:0] demod_sel, mode_state;
  logic [7:0] false_wake_cnt;
  logic [4:0] rc_trim_out;
  logic wake_out, demod_data_out, recovered_clock_out;
  int err_total = 0;
  int tests_run = 0;

  // Short counts keep every listening time base but the wider artificial wakeup windows to a few hundred cycles
  lfw_mode_ctrl #(.SLOT_CYC(SLOT), .WAKE_PULSE_CYC(10), .AW_UNIT_MS(2),
    .TO_UNIT_MS(2)) u_lfw_mode_ctrl (.mclk(mclk), .resetn(resetn),
    .fe_clk(fe_clk), .cfg(cfg), .clear_wake(clear_wake),
    .rc_auto_trim(rc_auto_trim), .carrier_det(carrier_det),
    .demod_in(demod_in), .rec_clk_in(rec_clk_in), .patt_match(patt_match),
    .patt_fail(patt_fail), .rssi_in(rssi_in), .chan_active(chan_active),
    .demod_sel(demod_sel), .rssi_stored(rssi_stored),
    .false_wake_cnt(false_wake_cnt), .wake_out(wake_out),
    .demod_data_out(demod_data_out),
    .recovered_clock_out(recovered_clock_out), .osc_en(osc_en),
    .rc_trim_out(rc_trim_out), .mode_state(mode_state));
  lfw_fe_model u_lfw_fe_model (.fe_clk(fe_clk), .resetn(resetn),
    .match_tgl(m_tgl), .fail_tgl(f_tgl), .rssi_val(rssi_val),
    .patt_match(patt_match), .patt_fail(patt_fail), .rssi_in(rssi_in));

  // Two unrelated clocks; the link clock starts off-phase
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    fe_clk = 1'b0;
    #7;
    forever #24 fe_clk = ~fe_clk;
  end

  task automatic finish_test();
    $display("Counts: tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Bounded wait for a state, then judge it
  task automatic wait_st(input logic [1:0] s);
    int k;
    k = 0;
    while (mode_state !== s && k < 300) begin
      @(negedge mclk);
      k++;
    end
    `CHK(mode_state, s)
  endtask : wait_st

  // Carrier on all channels until evaluation has begun
  task automatic carrier();
    carrier_det = 3'h7;
    wait_st(2'h1);
    `CHK(chan_active, 3'h7)
    carrier_det = 3'h0;
  endtask : carrier

  // Length of the next whole run of one chan_active value
  task automatic run_len(output logic [2:0] v, output int n);
    logic [2:0] p;
    int k;
    p = chan_active;
    k = 0;
    while (chan_active === p && k < 400) begin
      @(negedge mclk);
      k++;
    end
    v = chan_active;
    n = 0;
    while (chan_active === v && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask : run_len

  task automatic t_direct();
    cfg.correlator_en = 1'b0;
    cfg.manchester_decoder_en = 1'b1;
    rssi_val = 15'h1525; // ch3=5 ch2=9 ch1=5
    carrier();
    wait_st(2'h3);
    `CHK(rssi_stored, 15'h1525)
    `CHK(demod_sel, 2'h1)
    `CHK(wake_out, 1'b1)
    demod_in = 1'b1;
    rec_clk_in = 1'b1;
    cyc(5);
    `CHK(demod_data_out, 1'b1)
    `CHK(recovered_clock_out, 1'b1)
    demod_in = 1'b0;
    rec_clk_in = 1'b0;
    cyc(5);
    `CHK(demod_data_out, 1'b0)
    clear_wake = 1'b1;
    cyc(1);
    clear_wake = 1'b0;
    `CHK(mode_state, 2'h0)
    `CHK(wake_out, 1'b0)
    $display("done t_direct");
  endtask : t_direct

  // Scan, hidden data, then a failed pattern
  task automatic t_fail();
    cfg.scan_rotation_en = 1'b1;
    cfg.correlator_en = 1'b1;
    cfg.pre_wake_data_hide = 1'b0;
    rssi_val = 15'h4C42; // ch3=19 strongest
    carrier();
    wait_st(2'h2);
    `CHK(demod_sel, 2'h2)
    demod_in = 1'b1;
    cyc(5);
    `CHK(demod_data_out, 1'b0)
    f_tgl = ~f_tgl;
    wait_st(2'h0);
    `CHK(wake_out, 1'b0)
    `CHK(false_wake_cnt, 8'h01)
    demod_in = 1'b0;
    cfg.scan_rotation_en = 1'b0;
    $display("done t_fail");
  endtask : t_fail

  task automatic t_match();
    int n;
    cfg.pre_wake_data_hide = 1'b1;
    cfg.timeout_en = 1'b1;
    cfg.timeout_sel = 3'h0;
    carrier();
    wait_st(2'h2);
    demod_in = 1'b1;
    cyc(5);
    `CHK(demod_data_out, 1'b1)
    m_tgl = ~m_tgl;
    wait_st(2'h3);
    `CHK(wake_out, 1'b1)
    n = 0;
    while (mode_state === 2'h3 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n >= 2 * SLOT - SLOT && n <= 2 * SLOT + 1, 1'b1)
    `CHK(wake_out, 1'b0)
    demod_in = 1'b0;
    cfg.timeout_en = 1'b0;
    $display("done t_match");
  endtask : t_match

  task automatic t_scan();
    logic [2:0] v, w;
    int n;
    cfg.scan_rotation_en = 1'b1;
    run_len(v, n);
    // Each call skips the run it starts in, so runs lie two slots apart
    repeat (3) begin
      run_len(w, n);
      `CHK(w, {v[0], v[2:1]})
      `CHK(n, SLOT)
      v = w;
    end
    cfg.scan_rotation_en = 1'b0;
    $display("done t_scan");
  endtask : t_scan

  task automatic t_onoff();
    int ms[4] = '{1, 2, 4, 8};
    logic [1:0] code[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [2:0] v;
    int n;
    cfg.on_off_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg.off_time_sel = code[i];
      run_len(v, n);
      repeat (2) begin
        run_len(v, n);
        `CHK(n, (v == 3'h0) ? ms[i] * SLOT : SLOT)
      end
    end
    cfg.on_off_en = 1'b0;
    $display("done t_onoff");
  endtask : t_onoff

  task automatic t_aw();
    int n;
    cfg.art_wake_en = 1'b1;
    cfg.art_wake_sel = 3'h0;
    n = 0;
    while (wake_out !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (wake_out === 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n, 10)
    `CHK(mode_state, 2'h0)
    cfg.art_wake_en = 1'b0;
    $display("done t_aw");
  endtask : t_aw

  task automatic t_clk();
    cfg.clk_src = lfw_pkg::CS_XTAL;
    cyc(3);
    `CHK(osc_en, 3'h4)
    cfg.clk_src = lfw_pkg::CS_RC;
    cyc(3);
    `CHK(osc_en, 3'h2)
    cfg.clk_src = lfw_pkg::CS_EXT;
    cyc(3);
    `CHK(osc_en, 3'h1)
    cfg.rc_trim = 5'h15;
    cyc(3);
    `CHK(rc_trim_out, 5'h15)
    cfg.rc_cal_auto = 1'b1;
    rc_auto_trim = 5'h0A;
    cyc(3);
    `CHK(rc_trim_out, 5'h0A)
    $display("done t_clk");
  endtask : t_clk

  // Watchdog sized well above the fewer than two thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    finish_test();
  end

  // Two-channel setup first, then every scenario in turn
  initial begin
    resetn = 1'b0;
    cfg = '0;
    cfg.chan_en = 3'h3;
    {clear_wake, demod_in, rec_clk_in, m_tgl, f_tgl} = '0;
    carrier_det = 3'h0;
    rc_auto_trim = 5'h00;
    rssi_val = '0;
    cyc(20);
    `CHK({chan_active, wake_out, mode_state}, 6'h00)
    resetn = 1'b1;
    cyc(2);
    `CHK(chan_active, 3'h3)
    cfg.chan_en = 3'h7;
    cyc(2);
    `CHK(chan_active, 3'h7)
    $display("done t_reset");
    t_direct();
    t_fail();
    t_match();
    t_scan();
    t_onoff();
    t_aw();
    t_clk();
    finish_test();
  end
endmodule : tb
